// File: inc/fault_diag_params.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 input fault diagnostic register slice. Assumes a byte-wide register space.
*/
`ifndef FAULT_DIAG_PARAMS_SVH
`define FAULT_DIAG_PARAMS_SVH
`define OFS_INPUT_OV_LIVE 8'h35
`define OFS_BIAS_FAULT_LIVE 8'h37
`define OFS_BIAS_OV_CFG 8'h55
`define OFS_DIAG_DATA_CFG 8'h59
`define OFS_BATT_MON_UPPER 8'h5A
`define OFS_BATT_MON_LOW 8'h5B
`define OFS_IRQ_STATUS 8'h70
`define OFS_IRQ_MASK 8'h71
`define RST_BIAS_OV_CFG 8'h40
`define RST_DIAG_DATA_CFG 8'h00
`define RST_THRESHOLD 3'h2
`define RST_MARGIN_MV 8'h28
`define RST_SOURCE_TAG 4'h0
`define THR_MSB 7
`define THR_LSB 5
`define HOLD_BIT 0
`define CFG_RSVD_MSB 7
`define CFG_RSVD_LSB 4
`define SAMPLE_W 12
`define TAG_W 4
`define ADDR_W 8
`define IRQ_W 8
`define ACK_LATENCY_CYCLES 1
`endif

// File: inc/fault_diag_pkg.sv
/*
 Types of the input fault diagnostic register slice.
 Assumes fault_diag_params.svh is compiled alongside.
*/
package fault_diag_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage : fault_diag_pkg

// File: rtl/input_fault_diag_registers.sv
/*
 Register slice of the input fault diagnostic unit behind a classic
 Wishbone slave: live fault status, bias over-voltage threshold, monitor
 hold control, battery monitor sample and a sticky interrupt pair.
 Assumes fault inputs and sample strobes come from the same clock domain
 except the raw fault levels, which are synchronised here.
*/
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "fault_diag_params.svh"
//Contract
// - Bits 7..4 of input status show live over-voltage of channels 1..4.
// - Input status bits 3..0 read zero; host writes them as reset value.
// - Bias status bit 7 shows live high-current fault.
// - Bias status bit 6 shows live low-current fault.
// - Bias status bit 5 shows live over-voltage; bits 4..0 read zero.
// - Both live status registers are read-only, reset zero, not latched.
// - Threshold field bits 7..5 read/write, reset 010b, bits 4..0 read zero.
// - Threshold codes select margin: 0, 10mV, 40mV, 30mV steps, 190mV.
// - Hold bit clear: monitor data updates with every new result.
// - Hold bit set: monitor data updates are frozen.
// - Config bits 7..4 writable reserved, bits 3..1 read zero.
// - Upper eight sample bits read-only, reset zero.
// - Next register holds low nibble in 7..4, source tag in 3..0.
module input_fault_diag_registers
  import fault_diag_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [0:0] sel_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  // Raw fault levels
  input wire logic [3:0] input_ov_fault_i,
  input wire logic bias_high_current_i,
  input wire logic bias_low_current_i,
  input wire logic bias_ov_fault_i,
  // Converter results
  input wire logic sample_valid_i,
  input wire logic [11:0] sample_i,
  input wire logic [3:0] source_tag_i,
  // Threshold and hold to analog side
  output logic [2:0] bias_ov_threshold_o,
  output logic [7:0] bias_ov_margin_mv_o,
  output logic freeze_monitor_updates_o,
  // Interrupt
  output logic irq_o
);
  bus_state_t bus_state;
  logic [6:0] fault_meta;
  logic [6:0] fault_sync;
  logic [2:0] bias_ov_threshold;
  logic [3:0] cfg_reserved;
  logic freeze_monitor_updates;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [6:0] fault_prev;
  logic [7:0] fault_rise;
  logic [11:0] mon_sample;
  logic [3:0] mon_tag;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] next_dat;
  logic [7:0] input_ov_live_bits;
  logic [7:0] bias_fault_live_bits;

  // Margin in mV for a threshold code
  function automatic logic [7:0] margin_mv(input logic [2:0] code);
    logic [7:0] mv;
    mv = 8'h00;
    case (code)
      3'h0: mv = 8'h00;
      3'h1: mv = 8'h0A;
      3'h7: mv = 8'hBE;
      default: mv = 8'(8'h28 + 8'(({5'h00, code} - 8'h02) * 8'h1E));
    endcase
    return mv;
  endfunction : margin_mv

  // Two-stage synchroniser of raw fault levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_meta <= 7'h00;
      fault_sync <= 7'h00;
    end else begin
      fault_meta <= {input_ov_fault_i, bias_high_current_i, bias_low_current_i,
                     bias_ov_fault_i};
      fault_sync <= fault_meta;
    end
  end

  // Live views, reserved bits zero
  assign input_ov_live_bits = {fault_sync[6:3], 4'h0};
  assign bias_fault_live_bits = {fault_sync[2:0], 5'h00};

  // Bus decode
  assign wr_stb = cyc_i && stb_i && we_i && sel_i[0] && (bus_state == BUS_IDLE);
  assign rd_stb = cyc_i && stb_i && !we_i && (bus_state == BUS_IDLE);

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: if (cyc_i && stb_i) bus_state <= BUS_ACK;
        BUS_ACK: bus_state <= BUS_IDLE;
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end
  assign ack_o = (bus_state == BUS_ACK);

  // Writable configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_ov_threshold <= `RST_THRESHOLD;
      cfg_reserved <= 4'h0;
      freeze_monitor_updates <= 1'b0;
    end else if (wr_stb) begin
      if (adr_i == `OFS_BIAS_OV_CFG) begin
        bias_ov_threshold <= dat_i[`THR_MSB:`THR_LSB];
      end
      if (adr_i == `OFS_DIAG_DATA_CFG) begin
        cfg_reserved <= dat_i[`CFG_RSVD_MSB:`CFG_RSVD_LSB];
        freeze_monitor_updates <= dat_i[`HOLD_BIT];
      end
    end
  end
  assign bias_ov_threshold_o = bias_ov_threshold;
  assign freeze_monitor_updates_o = freeze_monitor_updates;

  // Margin decode for the analog comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_ov_margin_mv_o <= `RST_MARGIN_MV;
    end else begin
      bias_ov_margin_mv_o <= margin_mv(bias_ov_threshold);
    end
  end

  // Sample store, frozen while hold is set
  monitor_sample_store u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(sample_valid_i && !freeze_monitor_updates),
    .wr_sample_i(sample_i),
    .wr_tag_i(source_tag_i),
    .rd_sample_o(mon_sample),
    .rd_tag_o(mon_tag)
  );

  // Rising fault edges, sticky status, write one to clear
  assign fault_rise = {1'b0, fault_sync & ~fault_prev};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_prev <= 7'h00;
      irq_status <= 8'h00;
      irq_mask <= 8'h00;
    end else begin
      fault_prev <= fault_sync;
      if (wr_stb && adr_i == `OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~dat_i) | fault_rise;
      end else begin
        irq_status <= irq_status | fault_rise;
      end
      if (wr_stb && adr_i == `OFS_IRQ_MASK) begin
        irq_mask <= dat_i;
      end
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // Read mux
  always_comb begin
    next_dat = 8'h00;
    case (adr_i)
      `OFS_INPUT_OV_LIVE: next_dat = input_ov_live_bits;
      `OFS_BIAS_FAULT_LIVE: next_dat = bias_fault_live_bits;
      `OFS_BIAS_OV_CFG: next_dat = {bias_ov_threshold, 5'h00};
      `OFS_DIAG_DATA_CFG: next_dat = {cfg_reserved, 3'h0, freeze_monitor_updates};
      `OFS_BATT_MON_UPPER: next_dat = mon_sample[11:4];
      `OFS_BATT_MON_LOW: next_dat = {mon_sample[3:0], mon_tag};
      `OFS_IRQ_STATUS: next_dat = irq_status;
      `OFS_IRQ_MASK: next_dat = irq_mask;
      default: next_dat = 8'h00;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 8'h00;
    end else if (rd_stb) begin
      dat_o <= next_dat;
    end
  end

  // Status follows fault two cycles after pin
  a_live_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 input_ov_live_bits[7:4] == $past(input_ov_fault_i, 2))
    else $error("input live status does not follow fault");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    input_ov_live_bits[3:0] == 4'h0)
    else $error("reserved input status bits not zero");
  a_high_current: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 bias_fault_live_bits[7] == $past(bias_high_current_i, 2))
    else $error("high current bit wrong");
  a_low_current: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 bias_fault_live_bits[6] == $past(bias_low_current_i, 2))
    else $error("low current bit wrong");
  a_bias_ov: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 (bias_fault_live_bits[5] == $past(bias_ov_fault_i, 2))
    && bias_fault_live_bits[4:0] == 5'h00)
    else $error("bias over-voltage bit wrong");
  a_live_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bias_ov_fault_i [*3]) |-> !bias_fault_live_bits[5])
    else $error("live status latched a past fault");
  a_thr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && adr_i == `OFS_BIAS_OV_CFG |=> bias_ov_threshold == $past(dat_i[7:5]))
    else $error("threshold write not taken");
  a_margin_code: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h4 && $stable(bias_ov_threshold) |=> bias_ov_margin_mv_o == 8'h64)
    else $error("margin decode wrong");
  a_hold_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    freeze_monitor_updates |=> $stable(mon_sample))
    else $error("sample changed while held");
  a_update_free: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && !freeze_monitor_updates |=> mon_sample == $past(sample_i))
    else $error("sample not updated");
  a_cfg_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_DIAG_DATA_CFG |=> dat_o[3:1] == 3'h0)
    else $error("config read-only bits not zero");
  a_upper_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_BATT_MON_UPPER |=> dat_o == $past(mon_sample[11:4]))
    else $error("upper byte read wrong");
  a_low_nibble: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_BATT_MON_LOW |=> dat_o == $past({mon_sample[3:0], mon_tag}))
    else $error("low nibble read wrong");
  a_same_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && !freeze_monitor_updates |=>
    {mon_sample, mon_tag} == $past({sample_i, source_tag_i}))
    else $error("sample halves not from one conversion");

  // Margin decode per threshold code
  a_margin_none: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h0 |=> bias_ov_margin_mv_o == 8'h00)
    else $error("margin for code 0 wrong");
  a_margin_first: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h1 |=> bias_ov_margin_mv_o == 8'h0A)
    else $error("margin for code 1 wrong");
  a_margin_default: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h2 |=> bias_ov_margin_mv_o == 8'h28)
    else $error("margin for code 2 wrong");
  a_margin_three: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h3 |=> bias_ov_margin_mv_o == 8'h46)
    else $error("margin for code 3 wrong");
  a_margin_five: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h5 |=> bias_ov_margin_mv_o == 8'h82)
    else $error("margin for code 5 wrong");
  a_margin_six: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h6 |=> bias_ov_margin_mv_o == 8'hA0)
    else $error("margin for code 6 wrong");
  a_margin_top: assert property (@(posedge clk_i) disable iff (rst_i)
    bias_ov_threshold == 3'h7 |=> bias_ov_margin_mv_o == 8'hBE)
    else $error("margin for code 7 wrong");

  // Threshold register
  a_thr_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_stb && adr_i == `OFS_BIAS_OV_CFG) |=> $stable(bias_ov_threshold))
    else $error("threshold changed without write");
  a_thr_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_BIAS_OV_CFG |=> dat_o == {$past(bias_ov_threshold), 5'h00})
    else $error("threshold read wrong");

  // Live status reads
  a_live_rsvd_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_INPUT_OV_LIVE |=> dat_o[3:0] == 4'h0)
    else $error("input status reserved bits read nonzero");
  a_bias_rsvd_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_BIAS_FAULT_LIVE |=> dat_o[4:0] == 5'h00)
    else $error("bias status reserved bits read nonzero");
  a_live_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_INPUT_OV_LIVE |=> dat_o[7:4] == $past(fault_sync[6:3]))
    else $error("input status read wrong");
  a_bias_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_BIAS_FAULT_LIVE |=> dat_o[7:5] == $past(fault_sync[2:0]))
    else $error("bias status read wrong");
  a_live_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bias_low_current_i [*3]) |-> !bias_fault_live_bits[6])
    else $error("low current bit latched");
  a_live_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bias_high_current_i [*3]) |-> !bias_fault_live_bits[7])
    else $error("high current bit latched");

  // Hold control and monitor store
  a_hold_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && adr_i == `OFS_DIAG_DATA_CFG |=> freeze_monitor_updates == $past(dat_i[0]))
    else $error("hold write not taken");
  a_rsvd_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && adr_i == `OFS_DIAG_DATA_CFG |=> cfg_reserved == $past(dat_i[7:4]))
    else $error("reserved config write not taken");
  a_hold_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_stb && adr_i == `OFS_DIAG_DATA_CFG) |=> $stable(freeze_monitor_updates))
    else $error("hold changed without write");
  a_cfg_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && adr_i == `OFS_DIAG_DATA_CFG |=>
    dat_o == {$past(cfg_reserved), 3'h0, $past(freeze_monitor_updates)})
    else $error("config read wrong");
  a_tag_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    freeze_monitor_updates |=> $stable(mon_tag))
    else $error("tag changed while held");
  a_tag_free: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_valid_i && !freeze_monitor_updates |=> mon_tag == $past(source_tag_i))
    else $error("tag not updated");
  a_no_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    !sample_valid_i |=> $stable(mon_sample))
    else $error("sample changed without strobe");

  // Bus handshake
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_stb |=> $stable(dat_o))
    else $error("read data changed without read");

  // Sticky status and mask
  a_sticky_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_stb && adr_i == `OFS_IRQ_STATUS) |=>
    (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit lost without clear");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    |fault_rise |=> (irq_status & $past(fault_rise)) == $past(fault_rise))
    else $error("fault edge not recorded");
  a_status_spare: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_status[7] == 1'b0)
    else $error("unused status bit set");
  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && adr_i == `OFS_IRQ_MASK |=> irq_mask == $past(dat_i))
    else $error("mask write not taken");
endmodule : input_fault_diag_registers

// File: rtl/monitor_sample_store.sv
/*
 Holds the latest battery monitor sample and its source tag.
 Assumes samples arrive as single-cycle strobes on clk_i.
*/
`timescale 1ns/1ps
`include "fault_diag_params.svh"
module monitor_sample_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [11:0] wr_sample_i,
  input wire logic [3:0] wr_tag_i,
  // Read side
  output logic [11:0] rd_sample_o,
  output logic [3:0] rd_tag_o
);
  // Sample and tag stored together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_sample_o <= 12'h000;
      rd_tag_o <= `RST_SOURCE_TAG;
    end else if (wr_en_i) begin
      rd_sample_o <= wr_sample_i;
      rd_tag_o <= wr_tag_i;
    end
  end
endmodule : monitor_sample_store

// File: testbench/input_fault_diag_registers_tb.sv
/*
 Self-checking bench for input_fault_diag_registers over classic Wishbone.
 Assumes one 100 MHz clock and that the include path reaches inc/.
*/
`timescale 1ns/1ps
module input_fault_diag_registers_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [7:0] adr_i = 0;
  logic [0:0] sel_i = 0;
  logic [7:0] dat_i = 0;
  logic [3:0] ov = 0;
  logic bhc = 0;
  logic blc = 0;
  logic bov = 0;
  logic sv = 0;
  logic [11:0] smp = 0;
  logic [3:0] tag = 0;
  logic [7:0] dat_o;
  logic ack_o;
  logic [2:0] thr;
  logic [7:0] margin;
  logic frz;
  logic irq_o;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] q;
  logic [7:0] margins [8] = '{8'h00, 8'h0A, 8'h28, 8'h46, 8'h64, 8'h82, 8'hA0, 8'hBE};

  input_fault_diag_registers i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .input_ov_fault_i(ov), .bias_high_current_i(bhc), .bias_low_current_i(blc),
    .bias_ov_fault_i(bov), .sample_valid_i(sv), .sample_i(smp), .source_tag_i(tag),
    .bias_ov_threshold_o(thr), .bias_ov_margin_mv_o(margin),
    .freeze_monitor_updates_o(frz), .irq_o(irq_o)
  );

  always #5 clk_i = ~clk_i;

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) begin
      miscompares++;
      $display("unexpected ack: expected 1 seen 0");
      report_and_stop();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(what, exp, q);
  endtask : rdc

  task automatic pulse(input logic [11:0] s, input logic [3:0] t);
    @(posedge clk_i);
    sv <= 1'b1;
    smp <= s;
    tag <= t;
    @(posedge clk_i);
    sv <= 1'b0;
    @(posedge clk_i);
  endtask : pulse

  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values
    rdc("in_live", 8'h35, 8'h00);
    rdc("bias_live", 8'h37, 8'h00);
    rdc("ov_cfg", 8'h55, 8'h40);
    rdc("diag_cfg", 8'h59, 8'h00);
    rdc("mon_upper", 8'h5A, 8'h00);
    rdc("mon_low", 8'h5B, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    check("thr_out", 8'h02, {5'h00, thr});
    // Live faults, write to read-only ignored
    wb(1'b1, 8'h71, 8'h00);
    ov <= 4'b1010;
    repeat (4) @(posedge clk_i);
    rdc("in_live", 8'h35, 8'hA0);
    wb(1'b1, 8'h35, 8'hF0);
    rdc("in_live", 8'h35, 8'hA0);
    for (int i = 0; i < 3; i++) begin
      {bhc, blc, bov} <= 3'b100 >> i;
      repeat (4) @(posedge clk_i);
      rdc("bias_live", 8'h37, 8'h80 >> i);
    end
    {bhc, blc, bov} <= 3'b000;
    ov <= 4'h0;
    repeat (4) @(posedge clk_i);
    rdc("in_live", 8'h35, 8'h00);
    rdc("bias_live", 8'h37, 8'h00);
    // Sticky status, mask and level interrupt
    rdc("irq_stat", 8'h70, 8'h57);
    check("irq", {7'h00, irq_o}, 8'h00);
    wb(1'b1, 8'h71, 8'h40);
    check("irq", {7'h00, irq_o}, 8'h01);
    wb(1'b1, 8'h70, 8'h40);
    check("irq", {7'h00, irq_o}, 8'h00);
    rdc("irq_stat", 8'h70, 8'h17);
    // Every threshold code and its margin
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h55, {c[2:0], 5'h00});
      rdc("ov_cfg", 8'h55, {c[2:0], 5'h00});
      check("thr_out", {5'h00, c[2:0]}, {5'h00, thr});
      check("margin", margins[c], margin);
    end
    // Monitor sample pairing, hold and release
    pulse(12'hABC, 4'h5);
    rdc("mon_upper", 8'h5A, 8'hAB);
    rdc("mon_low", 8'h5B, 8'hC5);
    wb(1'b1, 8'h59, 8'h01);
    rdc("diag_cfg", 8'h59, 8'h01);
    check("freeze", {7'h00, frz}, 8'h01);
    pulse(12'h123, 4'h9);
    rdc("mon_upper", 8'h5A, 8'hAB);
    rdc("mon_low", 8'h5B, 8'hC5);
    wb(1'b1, 8'h59, 8'h00);
    check("freeze", 8'h00, {7'h00, frz});
    pulse(12'h123, 4'h9);
    rdc("mon_upper", 8'h5A, 8'h12);
    rdc("mon_low", 8'h5B, 8'h39);
    report_and_stop();
  end
endmodule : input_fault_diag_registers_tb
